// [verilog/rx_status_writeback.sv]
// Module: receive descriptor status word generator with Wishbone registers
`timescale 1ns/1ps
module rx_status_writeback
  import rx_wb_status_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Receive MAC side
  input  wire rx_mac_t     i_mac,
  // Receive DMA side
  input  wire logic        i_desc_full,
  input  wire logic        i_stat_ready,
  output logic             o_stat_valid,
  output logic [31:0]      o_stat_word,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // Interrupt
  output logic             o_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  wb_state_t          state_r;
  wb_state_t          state_nxt;
  logic [CNT_W-1:0]   byte_cnt_r;
  logic               first_r;
  logic               late_col_r;
  logic               phy_err_r;
  logic               pend_r;
  logic [31:0]        word_r;
  logic [31:0]        last_word_r;
  logic [31:0]        frm_cnt_r;
  logic               enable_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic               ack_r;
  logic [31:0]        rdat_r;
  logic [31:0]        final_word;
  logic [31:0]        mid_word;
  logic               accept;
  logic               desc_evt;
  logic               frame_evt;
  logic               overrun_evt;
  logic               wr_fire;
  logic               long_now;
  logic               runt_now;
  logic               crc_now;
  logic               frame_bad;

  // ****************************************
  // Helper functions
  // ****************************************
  // Decode used for both read mux and write strobes
  function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] reg_off);
    addr_is = (adr[7:2] == reg_off[7:2]);
  endfunction : addr_is

  function automatic logic [31:0] put_bit(input logic [31:0] w, input int pos, input logic v);
    logic [31:0] t;
    t      = w;
    t[pos] = v;
    put_bit = t;
  endfunction : put_bit

  // ****************************************
  // Frame classification
  // ****************************************
  assign long_now  = (byte_cnt_r > MAX_LEN);
  assign runt_now  = (byte_cnt_r < MIN_LEN);
  assign crc_now   = i_mac.crc_bad | phy_err_r | i_mac.phy_er;
  // Dribble alone never marks the frame bad
  assign frame_bad = crc_now | late_col_r | long_now | runt_now;

  always_comb
  begin
    final_word = ZERO_WORD;
    final_word = put_bit(final_word, BIT_FIRST_DESC, first_r);
    final_word = put_bit(final_word, BIT_LAST_DESC, 1'b1);
    final_word = put_bit(final_word, BIT_MCAST, i_mac.mcast);
    final_word = put_bit(final_word, BIT_TOO_LONG, long_now);
    final_word = put_bit(final_word, BIT_LATE_COL, late_col_r);
    final_word = put_bit(final_word, BIT_PHY_ERR,
                         phy_err_r | i_mac.phy_er);
    final_word = put_bit(final_word, BIT_DRIBBLE, i_mac.dribble);
    final_word = put_bit(final_word, BIT_CRC_ERR, crc_now);
    final_word = put_bit(final_word, BIT_RUNT, runt_now);
    final_word = put_bit(final_word, BIT_ERR_SUM, frame_bad);
  end

  // Early descriptors carry only position; class bits are not yet final
  always_comb
  begin
    mid_word = ZERO_WORD;
    mid_word = put_bit(mid_word, BIT_FIRST_DESC, first_r);
    mid_word = put_bit(mid_word, BIT_LAST_DESC, 1'b0);
  end

  // ****************************************
  // Sequencing
  // ****************************************
  assign accept      = pend_r & i_stat_ready;
  assign desc_evt    = (state_r == ST_RECV) & i_desc_full & ~i_mac.eof & (~pend_r | accept);
  assign frame_evt   = (state_r == ST_RECV) & i_mac.eof & (~pend_r | accept);
  // Descriptor closure while previous word still waits is dropped
  // Receive path has no backpressure, so a stall was not an option
  // Limitation: a dropped eof leaves the block receiving until the next eof
  assign overrun_evt = (state_r == ST_RECV) & (i_desc_full | i_mac.eof)
                       & pend_r & ~i_stat_ready;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (i_mac.sof && enable_r)
          state_nxt = ST_RECV;
      end
      ST_RECV:
      begin
        if (frame_evt)
          state_nxt = ST_EMIT;
      end
      ST_EMIT:
      begin
        if (accept)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Saturating count keeps too-long true for any oversize frame
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      byte_cnt_r <= '0;
    else if (state_r == ST_IDLE && i_mac.sof)
      byte_cnt_r <= '0;
    else if (state_r == ST_RECV && i_mac.byte_ok && byte_cnt_r != CNT_SAT)
      byte_cnt_r <= byte_cnt_r + 14'h0001;
  end

  // Error history held across the frame
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      late_col_r <= 1'b0;
      phy_err_r  <= 1'b0;
    end
    else if (state_r == ST_IDLE && i_mac.sof)
    begin
      late_col_r <= 1'b0;
      phy_err_r  <= 1'b0;
    end
    else if (state_r == ST_RECV)
    begin
      // Count excludes the current byte, so the 65th byte is the first late one
      if (i_mac.col && byte_cnt_r >= LATE_COL_LEN)
        late_col_r <= 1'b1;
      if (i_mac.phy_er)
        phy_err_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      first_r <= 1'b0;
    else if (state_r == ST_IDLE && i_mac.sof)
      first_r <= 1'b1;
    else if (desc_evt || frame_evt)
      first_r <= 1'b0;
  end

  // ****************************************
  // Status word handoff to DMA
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pend_r <= 1'b0;
      word_r <= ZERO_WORD;
    end
    else if (frame_evt)
    begin
      pend_r <= 1'b1;
      word_r <= final_word;
    end
    else if (desc_evt)
    begin
      pend_r <= 1'b1;
      word_r <= mid_word;
    end
    else if (accept)
      pend_r <= 1'b0;
  end

  assign o_stat_valid = pend_r;
  assign o_stat_word  = word_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      last_word_r <= ZERO_WORD;
      frm_cnt_r   <= ZERO_WORD;
    end
    else if (frame_evt)
    begin
      last_word_r <= final_word;
      frm_cnt_r   <= frm_cnt_r + 32'h0000_0001;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state: ack rises the cycle after the request is seen
  // Write lands on the edge where the master sees ack
  assign wr_fire = i_wb_cyc & i_wb_stb & i_wb_we & ack_r & i_wb_sel[0];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= i_wb_cyc & i_wb_stb & ~ack_r;
  end

  // Read data latched on the request edge, held until the next access
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdat_r <= ZERO_WORD;
    else if (i_wb_cyc && i_wb_stb && !ack_r)
    begin
      if (addr_is(i_wb_adr, REG_CTRL))
        rdat_r <= {31'h0000_0000, enable_r};
      else if (addr_is(i_wb_adr, REG_IRQ_STAT))
        rdat_r <= {28'h000_0000, irq_stat_r};
      else if (addr_is(i_wb_adr, REG_IRQ_MASK))
        rdat_r <= {28'h000_0000, irq_mask_r};
      else if (addr_is(i_wb_adr, REG_LAST_ST))
        rdat_r <= last_word_r;
      else if (addr_is(i_wb_adr, REG_FRM_CNT))
        rdat_r <= frm_cnt_r;
      else
        rdat_r <= ZERO_WORD;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      enable_r   <= 1'b0;
      irq_mask_r <= IRQ_MASK_RST;
    end
    else if (wr_fire)
    begin
      if (addr_is(i_wb_adr, REG_CTRL))
        enable_r <= i_wb_dat[0];
      if (addr_is(i_wb_adr, REG_IRQ_MASK))
        irq_mask_r <= i_wb_dat[IRQ_W-1:0];
    end
  end

  // ****************************************
  // Interrupt status, set beats clear
  // ****************************************
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb
  begin
    irq_set              = '0;
    irq_set[IRQ_FRAME]   = frame_evt;
    irq_set[IRQ_FRM_ERR] = frame_evt & frame_bad;
    irq_set[IRQ_DESC]    = desc_evt;
    irq_set[IRQ_OVERRUN] = overrun_evt;
    irq_clr              = '0;
    if (wr_fire && addr_is(i_wb_adr, REG_IRQ_STAT))
      irq_clr = i_wb_dat[IRQ_W-1:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
  end

  // Mask gates only the pin; status still records every event
  assign o_irq = |(irq_stat_r & irq_mask_r);

endmodule : rx_status_writeback

// [verilog/rx_wb_status_pkg.sv]
// Package: status word layout, register map and frame limits for rx status writeback
package rx_wb_status_pkg;

  // ****************************************
  // Descriptor status word bit positions
  // ****************************************
  localparam int BIT_CRC_ERR    = 1;
  localparam int BIT_DRIBBLE    = 2;
  localparam int BIT_PHY_ERR    = 3;
  localparam int BIT_LATE_COL   = 6;
  localparam int BIT_TOO_LONG   = 7;
  localparam int BIT_LAST_DESC  = 8;
  localparam int BIT_FIRST_DESC = 9;
  localparam int BIT_MCAST      = 10;
  localparam int BIT_RUNT       = 11;
  localparam int BIT_ERR_SUM    = 15;

  // ****************************************
  // Frame length limits in bytes
  // ****************************************
  localparam int          CNT_W        = 14;
  localparam logic [13:0] MAX_LEN      = 14'h0800;
  localparam logic [13:0] MIN_LEN      = 14'h0040;
  localparam logic [13:0] LATE_COL_LEN = 14'h0040;
  localparam logic [13:0] CNT_SAT      = 14'h3FFF;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_LAST_ST  = 8'h0C;
  localparam logic [7:0] REG_FRM_CNT  = 8'h10;

  localparam int          IRQ_W         = 4;
  localparam int          IRQ_FRAME     = 0;
  localparam int          IRQ_FRM_ERR   = 1;
  localparam int          IRQ_DESC      = 2;
  localparam int          IRQ_OVERRUN   = 3;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ****************************************
  // Receive MAC side signals
  // ****************************************
  typedef struct packed {
    logic sof;      // Pulse: SFD seen, frame begins
    logic byte_ok;  // Pulse: one byte received
    logic eof;      // Pulse: frame ended
    logic col;      // Level: collision seen
    logic phy_er;   // Level: PHY receive error
    logic mcast;    // Valid with eof: multicast destination
    logic crc_bad;  // Valid with eof: FCS mismatch
    logic dribble;  // Valid with eof: extra bits past last byte
  } rx_mac_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_EMIT = 2'b11
  } wb_state_t;

endpackage : rx_wb_status_pkg

// [bench/rx_status_writeback_properties.sv]
// Checker: port-level properties of the receive status writeback block
`timescale 1ns/1ps
module rx_status_writeback_properties
  import rx_wb_status_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Status side
  input  wire rx_mac_t     i_mac,
  input  wire logic        i_desc_full,
  input  wire logic        i_stat_ready,
  input  wire logic        o_stat_valid,
  input  wire logic [31:0] o_stat_word,
  // Bus side
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        o_wb_ack
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_last;
    o_stat_valid && o_stat_word[BIT_LAST_DESC];
  endsequence

  a_ack_next: assert property (s_req |=> o_wb_ack)
    else $error("bus ack not one cycle after request");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus ack longer than one cycle");
  a_word_hold: assert property (o_stat_valid && !i_stat_ready |=> o_stat_valid && $stable(o_stat_word))
    else $error("status word changed before accepted");
  a_word_cause: assert property ($rose(o_stat_valid) |-> $past(i_mac.eof || i_desc_full))
    else $error("status word without frame end or descriptor fill");
  a_mid_clear: assert property (o_stat_valid && !o_stat_word[BIT_LAST_DESC] |-> (o_stat_word & 32'hFFFF_FDFF) == 32'h0)
    else $error("non-last word carries flags");
  a_err_sum: assert property (s_last |-> o_stat_word[BIT_ERR_SUM] == (o_stat_word[1] | o_stat_word[6] | o_stat_word[7] | o_stat_word[11]))
    else $error("error summary mismatch");
  a_crc_phy: assert property (s_last ##0 o_stat_word[BIT_PHY_ERR] |-> o_stat_word[BIT_CRC_ERR])
    else $error("phy error without crc error");
  a_len_excl: assert property (s_last |-> !(o_stat_word[BIT_TOO_LONG] && o_stat_word[BIT_RUNT]))
    else $error("frame both runt and too long");
  a_rsvd_zero: assert property (o_stat_valid |-> (o_stat_word & 32'hFFFF_7031) == 32'h0)
    else $error("reserved status bits set");
endmodule : rx_status_writeback_properties

bind rx_status_writeback rx_status_writeback_properties u_rx_status_writeback_properties (
  .i_clk, .i_rst_n, .i_mac, .i_desc_full, .i_stat_ready, .o_stat_valid, .o_stat_word,
  .i_wb_cyc, .i_wb_stb, .o_wb_ack);

// [bench/dma_sink_model.sv]
// Receive DMA sink model taking status words promptly or with stalls
`timescale 1ns/1ps
module dma_sink_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Status side
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_word,
  output logic             o_ready,
  output logic             o_got,
  output logic [31:0]      o_word,
  output logic             o_good
);
  logic [1:0] ph_r;
  // Stalls three edges in four to stress the hold of a waiting word
  assign o_ready = !i_slow || ph_r == 2'h3;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ph_r   <= 2'h0;
      o_got  <= 1'h0;
      o_word <= 32'h0;
      o_good <= 1'h0;
    end
    else
    begin
      ph_r  <= ph_r + 2'h1;
      o_got <= i_valid && o_ready;
      if (i_valid && o_ready)
      begin
        o_word <= i_word;
        // Dribble never spoils a frame; flags trusted only on first or last
        o_good <= |i_word[9:8] && !i_word[15];
      end
    end
  end
endmodule : dma_sink_model

// [bench/tb_top.sv]
// Testbench: frames, descriptor splits, registers and interrupt of status writeback
`timescale 1ns/1ps
module tb_top;
  import rx_wb_status_pkg::*;
  logic        i_clk, i_rst_n, i_desc_full, slow, ready, got, good;
  logic        cyc, stb, we, ack, irq, valid;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd_q, word, got_word, exp_q[$];
  rx_mac_t     mac;
  int          fails, n_checks, cyc_n;

  rx_status_writeback u_rx_status_writeback (.i_clk, .i_rst_n, .i_mac(mac), .i_desc_full,
    .i_stat_ready(ready), .o_stat_valid(valid), .o_stat_word(word), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));
  dma_sink_model u_dma_sink_model (.i_clk, .i_rst_n, .i_slow(slow), .i_valid(valid),
    .i_word(word), .o_ready(ready), .o_got(got), .o_word(got_word), .o_good(good));

  initial
  begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Hang guard, well above the longest frame sequence
  always @(posedge i_clk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      fails++;
      stop_test;
    end
  end

  always @(posedge i_clk)
    if (got === 1'h1)
      check(got_word, exp_q.pop_front());

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clk); while (ack !== 1'h1);
    rd_q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge i_clk);
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    check(rd_q, e);
  endtask : rd_chk

  // f: mcast, crc_bad, dribble, phy_er; nd descriptor fills, one every 100 bytes
  task automatic frame(input int n, input int nd, input logic [3:0] f, input int col_at);
    logic [31:0] e;
    int i;
    e = 32'h0;
    e[BIT_MCAST] = f[3];
    e[BIT_FIRST_DESC] = (nd == 0);
    e[BIT_LAST_DESC] = 1'h1;
    e[BIT_TOO_LONG] = (n > 2048);
    e[BIT_RUNT] = (n < 64);
    e[BIT_LATE_COL] = (col_at > 64);
    e[BIT_PHY_ERR] = f[0];
    e[BIT_DRIBBLE] = f[1];
    e[BIT_CRC_ERR] = f[2] | f[0];
    e[BIT_ERR_SUM] = e[1] | e[6] | e[7] | e[11];
    if (nd > 0)
      exp_q.push_back(32'h200);
    for (i = 1; i < nd; i++)
      exp_q.push_back(32'h0);
    exp_q.push_back(e);
    mac <= 8'h80;
    @(posedge i_clk);
    for (i = 1; i <= n; i++)
    begin
      mac <= {3'h2, 1'(i == col_at), 1'(f[0] && i == n / 2), 3'h0};
      i_desc_full <= (i % 100 == 0) && (i / 100 <= nd);
      @(posedge i_clk);
    end
    mac <= {5'h04, f[3:1]};
    i_desc_full <= 1'h0;
    @(posedge i_clk);
    mac <= 8'h0;
    for (i = 0; i < 200 && exp_q.size() > 0; i++)
      @(posedge i_clk);
    check(32'(exp_q.size()), 32'h0);
  endtask : frame

  task automatic t_regs;
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_IRQ_MASK, 32'h0);
    rd_chk(8'h40, 32'h0);
    wb(1'h1, REG_CTRL, 32'h1);
    wb(1'h1, REG_IRQ_MASK, 32'h3);
    rd_chk(REG_IRQ_MASK, 32'h3);
  endtask : t_regs

  task automatic t_class;
    frame(100, 0, 4'h8, 0);
    frame(63, 0, 4'h0, 0);
    frame(64, 0, 4'h0, 0);
    frame(2048, 0, 4'h0, 0);
    frame(2049, 0, 4'h0, 0);
    frame(200, 0, 4'h0, 100);
    frame(200, 0, 4'h0, 30);
    frame(100, 0, 4'h1, 0);
    frame(100, 0, 4'h4, 0);
    frame(100, 0, 4'h2, 0);
    check({31'h0, good}, 32'h1);
  endtask : t_class

  task automatic t_split;
    slow <= 1'h1;
    frame(350, 2, 4'hC, 150);
    frame(250, 1, 4'h8, 0);
    slow <= 1'h0;
  endtask : t_split

  task automatic t_irq;
    check({31'h0, irq}, 32'h1);
    rd_chk(REG_IRQ_STAT, 32'h7);
    rd_chk(REG_FRM_CNT, 32'hC);
    wb(1'h1, REG_FRM_CNT, 32'h0);
    rd_chk(REG_FRM_CNT, 32'hC);
    rd_chk(REG_LAST_ST, 32'h500);
    wb(1'h1, REG_IRQ_STAT, 32'h7);
    rd_chk(REG_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    wb(1'h1, REG_IRQ_MASK, 32'h0);
    frame(80, 0, 4'h0, 0);
    check({31'h0, irq}, 32'h0);
    wb(1'h1, REG_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wb(1'h1, REG_IRQ_STAT, 32'hF);
    check({31'h0, irq}, 32'h0);
  endtask : t_irq

  // Second descriptor pulse while the first word waits: overrun, event dropped
  task automatic t_ovr;
    int i;
    slow <= 1'h1;
    exp_q.push_back(32'h200);
    exp_q.push_back(32'h8900);
    mac <= 8'h80;
    do @(posedge i_clk); while (ready !== 1'h1);
    mac <= 8'h0;
    i_desc_full <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_desc_full <= 1'h0;
    for (i = 0; i < 50 && exp_q.size() > 1; i++)
      @(posedge i_clk);
    mac <= 8'h20;
    @(posedge i_clk);
    mac <= 8'h0;
    for (i = 0; i < 50 && exp_q.size() > 0; i++)
      @(posedge i_clk);
    check(32'(exp_q.size()), 32'h0);
    slow <= 1'h0;
    rd_chk(REG_IRQ_STAT, 32'hF);
    rd_chk(REG_FRM_CNT, 32'hE);
    check({31'h0, irq}, 32'h1);
  endtask : t_ovr

  initial
  begin
    i_rst_n = 1'h0;
    mac = 8'h0;
    i_desc_full = 1'h0;
    slow = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h0;
    wdat = 32'h0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    t_regs;
    t_class;
    t_split;
    t_irq;
    t_ovr;
    stop_test;
  end
endmodule : tb_top
